// file: wdt_defs.vh
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

`define OFS_REFRESH      8'h00
`define OFS_CONTROL      8'h04
`define OFS_STATUS       8'h08
`define OFS_RESET_CTRL   8'h0C
`define OFS_COUNT_STOP   8'h10

`define CTL_TOPS_LO      0
`define CTL_DIV_LO       4
`define CTL_RPES_LO      8
`define CTL_RPSS_LO      12
`define CTL_RESET_VAL    16'h33F3
`define CTL_WMASK        16'h33F3

`define ST_UNDERFLOW_BIT 14
`define ST_REFERR_BIT    15

`define BOOT_TOPS_LO     0
`define BOOT_DIV_LO      2
`define BOOT_RPES_LO     6
`define BOOT_RPSS_LO     8
`define BOOT_RSTIRQ_BIT  10
`define BOOT_CSTOP_BIT   11

`define DIV_1            4'h0
`define DIV_16           4'h2
`define DIV_32           4'h3
`define DIV_64           4'h4
`define DIV_256          4'h5
`define DIV_128          4'hF

`define TOUT_0           14'h03FF
`define TOUT_1           14'h0FFF
`define TOUT_2           14'h1FFF
`define TOUT_3           14'h07FF

`define REFRESH_ARM      8'h00
`define REFRESH_FIRE     8'hFF

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// file: wdt_prescaler.v
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler #(
  parameter WIDTH = 8
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       clear,
  input  wire       src_tick,
  input  wire [3:0] divide_select,
  output reg        count_tick
);
`include "wdt_defs.vh"

  reg [WIDTH-1:0] div_cnt_reg;

  // Ratio minus one; unknown codes fall back to no division.
  function [WIDTH-1:0] div_limit;
    input [3:0] code;
    begin
      case (code)
        `DIV_16:  div_limit = 8'h0F;
        `DIV_32:  div_limit = 8'h1F;
        `DIV_64:  div_limit = 8'h3F;
        `DIV_128: div_limit = 8'h7F;
        `DIV_256: div_limit = 8'hFF;
        default:  div_limit = 8'h00;
      endcase
    end
  endfunction

  always @(posedge core_clk) begin
    if (!nrst || clear) begin
      div_cnt_reg <= {WIDTH{1'b0}};
      count_tick  <= 1'b0;
    end else if (src_tick) begin
      if (div_cnt_reg >= div_limit(divide_select)) begin // R2 R3
        div_cnt_reg <= {WIDTH{1'b0}};
        count_tick  <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
        count_tick  <= 1'b0;
      end
    end else begin
      count_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: wdt_refresh_seq.v
`timescale 1ns/1ps
`default_nettype none
module wdt_refresh_seq (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       wr_stb,
  input  wire [7:0] wr_byte,
  output reg        refresh
);
`include "wdt_defs.vh"

  reg armed_reg;

  always @(posedge core_clk) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
      refresh   <= 1'b0;
    end else begin
      refresh <= 1'b0;
      if (wr_stb) begin
        // Any write other than the arming byte breaks the sequence.
        armed_reg <= (wr_byte == `REFRESH_ARM); // R17
        if (armed_reg && wr_byte == `REFRESH_FIRE)
          refresh <= 1'b1; // R5 R17
      end
    end
  end
endmodule
`default_nettype wire

// file: independent_watchdog.v
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Timeout counter is a 14-bit down-counter on the prescaled clock.
// [R2] Prescaler divides the watchdog clock by 1, 16, 32, 64, 128 or 256.
// [R3] Divide codes 0,2,3,4,5,F in bits 7:4 give /1,/16,/32,/64,/256,/128.
// [R4] Auto-start mode counts down by itself once reset is released.
// [R5] Register-start mode: 00h then FFh refreshes, starting or reloading.
// [R6] Reset stops the counter and restores counter and registers.
// [R7] Register-start mode only: underflow or refresh error stops counting.
// [R8] Window positions split the period; refresh outside it is an error.
// [R9] Underflow or refresh error raises reset or interrupt, per select bit.
// [R10] Current counter value is readable in the status register.
// [R11] Counting halts in low-power states only when count-stop asks for it.
// [R12] Count-stop covers all low-power states; drives a count-stop output.
// [R13] Auto-start mode takes all settings from the boot option word.
// [R14] Register-start mode uses control, reset and count-stop registers.
// [R15] Separate event outputs for underflow and for refresh error.
// [R16] Three internal outputs: reset, interrupt and count-stop control.
// [R17] Only FFh directly after 00h counts as a refresh.
// [R18] Refresh error flag stays set until software writes zero to status.
module independent_watchdog (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        dedicated_watchdog_clock,
  input  wire        low_power_state,
  input  wire        auto_start_mode,
  input  wire [15:0] boot_option_word,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         reset_request,
  output reg         irq_request,
  output reg         underflow_event,
  output reg         refresh_error_event,
  output wire        count_stop_control
);
`include "wdt_defs.vh"
  localparam [15:0] ctl_wmask = `CTL_WMASK;

  // Asynchronous inputs pass two flip-flops before any logic reads them.
  reg [1:0]  wclk_sync_reg;
  reg        wclk_prev_reg;
  reg [1:0]  lp_sync_reg;
  reg [1:0]  mode_sync_reg;

  reg [15:0] control_reg;
  reg        reset_or_irq_select_reg;
  reg        low_power_count_stop_reg;
  reg        refresh_error_flag_reg;
  reg        underflow_flag_reg;
  reg [13:0] counter_reg;
  reg        counting_reg;
  reg        cfg_loaded_reg;
  reg        auto_mode_reg;

  reg        aw_held_reg;
  reg [7:0]  aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  wire       src_tick;
  wire       count_tick;
  wire       refresh;
  wire       wr_fire;
  wire       refresh_wr;
  wire       status_wr;

  reg  [3:0] divide_select;
  reg  [1:0] timeout_select;
  reg  [1:0] window_start_select;
  reg  [1:0] window_end_select;
  reg        reset_or_irq_select;
  reg        low_power_count_stop;
  reg [13:0] load_value;
  reg [13:0] quarter;
  reg [13:0] win_start_val;
  reg [13:0] win_end_val;
  reg        in_window;
  reg        halted;
  reg        underflow;
  reg        refresh_error;

  function [13:0] timeout_load;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    timeout_load = `TOUT_0;
        2'd1:    timeout_load = `TOUT_1;
        2'd2:    timeout_load = `TOUT_2;
        default: timeout_load = `TOUT_3;
      endcase
    end
  endfunction

  // Converts a 2-bit window position into a count threshold.
  function [13:0] window_pos;
    input [1:0]  sel;
    input [13:0] q;
    input [13:0] full;
    input        is_start;
    begin
      case (sel)
        2'd0:    window_pos = q + q + q;
        2'd1:    window_pos = q + q;
        2'd2:    window_pos = q;
        default: window_pos = is_start ? full : 14'h0000;
      endcase
    end
  endfunction

  // Left out of reset so the mode strap has settled by the time nrst rises.
  always @(posedge core_clk) begin
    wclk_sync_reg <= {wclk_sync_reg[0], dedicated_watchdog_clock};
    wclk_prev_reg <= wclk_sync_reg[1];
    lp_sync_reg   <= {lp_sync_reg[0], low_power_state};
    mode_sync_reg <= {mode_sync_reg[0], auto_start_mode};
  end

  assign src_tick = wclk_sync_reg[1] & ~wclk_prev_reg; // R1

  // Boot settings in auto-start mode, software registers otherwise.
  always @* begin
    if (auto_mode_reg) begin // R13
      divide_select        = boot_option_word[`BOOT_DIV_LO +: 4];
      timeout_select       = boot_option_word[`BOOT_TOPS_LO +: 2];
      window_start_select  = boot_option_word[`BOOT_RPSS_LO +: 2];
      window_end_select    = boot_option_word[`BOOT_RPES_LO +: 2];
      reset_or_irq_select  = boot_option_word[`BOOT_RSTIRQ_BIT];
      low_power_count_stop = boot_option_word[`BOOT_CSTOP_BIT];
    end else begin // R14
      divide_select        = control_reg[`CTL_DIV_LO +: 4];
      timeout_select       = control_reg[`CTL_TOPS_LO +: 2];
      window_start_select  = control_reg[`CTL_RPSS_LO +: 2];
      window_end_select    = control_reg[`CTL_RPES_LO +: 2];
      reset_or_irq_select  = reset_or_irq_select_reg;
      low_power_count_stop = low_power_count_stop_reg;
    end
    load_value    = timeout_load(timeout_select);
    quarter       = {2'b00, load_value[13:2]};
    win_start_val = window_pos(window_start_select, quarter,
                               load_value, 1'b1);
    win_end_val   = window_pos(window_end_select, quarter,
                               load_value, 1'b0);
    in_window     = (counter_reg <= win_start_val) &&
                    (counter_reg > win_end_val); // R8
    halted        = low_power_count_stop & lp_sync_reg[1]; // R11 R12
    underflow     = counting_reg && count_tick && !halted &&
                    (counter_reg == 14'h0000);
    refresh_error = counting_reg && refresh && !in_window; // R8
  end

  assign count_stop_control = low_power_count_stop; // R12 R16

  wdt_prescaler #(
    .WIDTH(8)
  ) wdt_prescaler_inst (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .clear         (refresh),
    .src_tick      (src_tick),
    .divide_select (divide_select),
    .count_tick    (count_tick)
  );

  wdt_refresh_seq wdt_refresh_seq_inst (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr_stb   (refresh_wr),
    .wr_byte  (w_data_reg[7:0]),
    .refresh  (refresh)
  );

  // Counter; reset puts everything back to its initial value.
  always @(posedge core_clk) begin
    if (!nrst) begin // R6
      counter_reg    <= 14'h3FFF;
      counting_reg   <= 1'b0;
      cfg_loaded_reg <= 1'b0;
      auto_mode_reg  <= 1'b0;
    end else if (!cfg_loaded_reg) begin
      // The strap is captured once, after the synchroniser has settled.
      cfg_loaded_reg <= 1'b1;
      auto_mode_reg  <= mode_sync_reg[1];
      if (mode_sync_reg[1])
        counter_reg  <= timeout_load(boot_option_word[`BOOT_TOPS_LO +: 2]);
      counting_reg   <= mode_sync_reg[1]; // R4
    end else if (refresh_error) begin
      counter_reg  <= load_value;
      counting_reg <= auto_mode_reg; // R7
    end else if (refresh) begin
      counter_reg  <= load_value; // R5
      counting_reg <= 1'b1;
    end else if (underflow) begin
      counter_reg  <= load_value;
      counting_reg <= auto_mode_reg; // R7
    end else if (counting_reg && count_tick && !halted) begin
      counter_reg <= counter_reg - 1'b1; // R1 R11
    end
  end

  // Events and request outputs are one-cycle pulses.
  always @(posedge core_clk) begin
    if (!nrst) begin
      reset_request       <= 1'b0;
      irq_request         <= 1'b0;
      underflow_event     <= 1'b0;
      refresh_error_event <= 1'b0;
    end else begin
      underflow_event     <= underflow; // R15
      refresh_error_event <= refresh_error; // R15
      reset_request       <= (underflow | refresh_error) &
                             ~reset_or_irq_select; // R9 R16
      irq_request         <= (underflow | refresh_error) &
                             reset_or_irq_select; // R9 R16
    end
  end

  // AXI4-Lite write: address and data are held separately, either first.
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign refresh_wr    = wr_fire && aw_addr_reg == `OFS_REFRESH &&
                         w_strb_reg[0];
  assign status_wr     = wr_fire && aw_addr_reg == `OFS_STATUS;

  always @(posedge core_clk) begin
    if (!nrst) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          `OFS_REFRESH, `OFS_CONTROL, `OFS_STATUS,
          `OFS_RESET_CTRL, `OFS_COUNT_STOP:
            s_axi_bresp <= `RESP_OKAY;
          default:
            s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software registers. Settings are ignored while in auto-start mode.
  always @(posedge core_clk) begin
    if (!nrst) begin // R6
      control_reg              <= `CTL_RESET_VAL;
      reset_or_irq_select_reg  <= 1'b0;
      low_power_count_stop_reg <= 1'b0;
    end else if (wr_fire && !auto_mode_reg) begin
      if (aw_addr_reg == `OFS_CONTROL) begin
        if (w_strb_reg[0])
          control_reg[7:0] <= w_data_reg[7:0] & ctl_wmask[7:0];
        if (w_strb_reg[1])
          control_reg[15:8] <= w_data_reg[15:8] & ctl_wmask[15:8];
      end
      if (aw_addr_reg == `OFS_RESET_CTRL && w_strb_reg[0])
        reset_or_irq_select_reg <= w_data_reg[0]; // R14
      if (aw_addr_reg == `OFS_COUNT_STOP && w_strb_reg[0])
        low_power_count_stop_reg <= w_data_reg[0]; // R14
    end
  end

  // Flags: a new event in the clearing cycle keeps the flag set.
  always @(posedge core_clk) begin
    if (!nrst) begin
      refresh_error_flag_reg <= 1'b0;
      underflow_flag_reg     <= 1'b0;
    end else begin
      if (refresh_error)
        refresh_error_flag_reg <= 1'b1; // R8 R18
      else if (status_wr && w_strb_reg[1] &&
               !w_data_reg[`ST_REFERR_BIT])
        refresh_error_flag_reg <= 1'b0; // R18
      if (underflow)
        underflow_flag_reg <= 1'b1;
      else if (status_wr && w_strb_reg[1] &&
               !w_data_reg[`ST_UNDERFLOW_BIT])
        underflow_flag_reg <= 1'b0;
    end
  end

  // AXI4-Lite read: one data beat the cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `OFS_REFRESH:
          s_axi_rdata <= 32'h0000_00FF;
        `OFS_CONTROL:
          s_axi_rdata <= {16'h0000, control_reg};
        `OFS_STATUS:
          s_axi_rdata <= {16'h0000, refresh_error_flag_reg,
                          underflow_flag_reg, counter_reg}; // R10
        `OFS_RESET_CTRL:
          s_axi_rdata <= {31'h0000_0000, reset_or_irq_select_reg};
        `OFS_COUNT_STOP:
          s_axi_rdata <= {31'h0000_0000, low_power_count_stop_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: wdt_sva.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_sva (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_request,
  input wire logic irq_request,
  input wire logic underflow_event,
  input wire logic refresh_error_event
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  read_once_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after it was taken");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  write_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  write_once_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after it was taken");
  req_excl_a: assert property (!(reset_request && irq_request))
    else $error("reset and interrupt raised together");
  req_pulse_a: assert property (
    reset_request || irq_request |=> !(reset_request || irq_request))
    else $error("request longer than one cycle");
  event_req_a: assert property (
    underflow_event || refresh_error_event
    |-> ##[0:1] (reset_request || irq_request))
    else $error("event without request");
  req_cause_a: assert property (
    reset_request || irq_request |-> underflow_event ||
    refresh_error_event || $past(underflow_event || refresh_error_event))
    else $error("request without event");
endmodule
bind independent_watchdog wdt_sva wdt_sva_inst (
  .core_clk(core_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .reset_request(reset_request),
  .irq_request(irq_request), .underflow_event(underflow_event),
  .refresh_error_event(refresh_error_event));
`default_nettype wire

// file: wdt_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_sys_model (
  input  wire logic core_clk,
  input  wire logic reset_request,
  input  wire logic irq_request,
  input  wire logic underflow_event,
  input  wire logic refresh_error_event,
  output var  logic dedicated_watchdog_clock,
  output var  int   rst_cnt,
  output var  int   irq_cnt,
  output var  int   uf_cnt,
  output var  int   err_cnt
);
  // Free-running 40 ns source, offset so it never lines up with core_clk.
  initial begin
    dedicated_watchdog_clock = 1'b0;
    #7;
    forever #20 dedicated_watchdog_clock = ~dedicated_watchdog_clock;
  end
  // The counters are two-state ints, so they start at zero on their own.
  always @(posedge core_clk) begin
    if (reset_request) rst_cnt <= rst_cnt + 1;
    if (irq_request) irq_cnt <= irq_cnt + 1;
    if (underflow_event) uf_cnt <= uf_cnt + 1;
    if (refresh_error_event) err_cnt <= err_cnt + 1;
  end
endmodule
`default_nettype wire

// file: independent_watchdog_test.sv
`timescale 1ns/1ps
`default_nettype none
module independent_watchdog_test;
  logic        core_clk, nrst, lp, auto_m, awvalid, wvalid, arvalid;
  logic        awready, wready, bvalid, arready, rvalid, cs_out, wclk;
  logic        rst_rq, irq_rq, uf_ev, err_ev;
  logic [15:0] boot;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  int          rst_cnt, irq_cnt, uf_cnt, err_cnt, b;
  int          err_total, tests_run, cyc, i, c1, c2, et;
  logic [3:0]  codes [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
  int          divs [6] = '{1, 16, 32, 64, 256, 128};
  int          tsel [3] = '{3, 1, 2};
  int          tl [3] = '{2047, 4095, 8191};
  independent_watchdog independent_watchdog_inst (
    .core_clk(core_clk), .nrst(nrst), .dedicated_watchdog_clock(wclk),
    .low_power_state(lp), .auto_start_mode(auto_m), .boot_option_word(boot),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .reset_request(rst_rq),
    .irq_request(irq_rq), .underflow_event(uf_ev),
    .refresh_error_event(err_ev), .count_stop_control(cs_out));
  wdt_sys_model wdt_sys_model_inst (
    .core_clk(core_clk), .reset_request(rst_rq), .irq_request(irq_rq),
    .underflow_event(uf_ev), .refresh_error_event(err_ev),
    .dedicated_watchdog_clock(wclk), .rst_cnt(rst_cnt), .irq_cnt(irq_cnt),
    .uf_cnt(uf_cnt), .err_cnt(err_cnt));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // Ready is sampled at the negedge, where it already equals its edge value.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge core_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      @(posedge core_clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
  endtask
  task rd_reg(input logic [7:0] a);
    logic ok;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge core_clk);
      ok = arready;
      @(posedge core_clk);
    end while (!ok);
    arvalid <= 1'b0;
    do begin
      @(negedge core_clk);
      ok = rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge core_clk);
    end while (!ok);
  endtask
  task cnt(output int c);
    rd_reg(8'h08);
    check("count known", ^rd[13:0] !== 1'bx, 1);
    c = rd[13:0];
  endtask
  task refresh;
    wr(8'h00, 32'h0000_0000, 4'h1);
    wr(8'h00, 32'h0000_00FF, 4'h1);
  endtask
  task automatic wait_on(ref int c);
    int s;
    int n;
    s = c;
    n = 0;
    while (c == s && n < 15000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (3) @(posedge core_clk);
  endtask
  task do_reset(input logic m);
    nrst <= 1'b0;
    auto_m <= m;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
  endtask
  initial begin
    nrst = 1'b0; lp = 1'b0; auto_m = 1'b0; boot = 16'h0FC0;
    awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'h0;
    @(posedge core_clk);
    do_reset(1'b0);
    rd_reg(8'h04); check("control reset", rd, 32'h0000_33F3);
    rd_reg(8'h14); check("unmapped resp", rr, 2'b10);
    repeat (200) @(posedge core_clk);
    rd_reg(8'h08); check("idle status", rd, 32'h0000_3FFF);
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      wr(8'h04, 32'h0000_3300 | {24'h0, codes[i], 4'h0}, 4'h3);
      refresh;
      cnt(c1); check("reload", c1 > 1000 && c1 <= 1023, 1);
      repeat (4000) @(posedge core_clk);
      cnt(c2);
      et = 4000 / (10 * divs[i]);
      check("divide", c1 - c2 >= et - 2 && c1 - c2 <= et + 2, 1);
    end
    wr(8'h04, 32'h0000_3300, 4'h3);
    refresh;
    repeat (1000) @(posedge core_clk);
    cnt(c1);
    wr(8'h00, 32'h0000_0000, 4'h1);
    wr(8'h00, 32'h0000_0055, 4'h1);
    wr(8'h00, 32'h0000_00FF, 4'h1);
    cnt(c2); check("broken sequence", c2 < c1, 1);
    refresh;
    cnt(c1); check("good sequence", c1 > c2, 1);
    $display("refresh test done");
    wr(8'h0C, 32'h0000_0001, 4'h1);
    wait_on(uf_cnt);
    check("underflow event", uf_cnt, 1);
    check("irq count", irq_cnt, 1);
    check("reset count", rst_cnt, 0);
    rd_reg(8'h08); check("underflow flag", rd[14], 1);
    cnt(c1);
    repeat (200) @(posedge core_clk);
    cnt(c2); check("stop on underflow", c2, c1);
    $display("underflow test done");
    wr(8'h0C, 32'h0000_0000, 4'h1);
    wr(8'h04, 32'h0000_2300, 4'h3);
    refresh;
    refresh;
    wait_on(err_cnt);
    check("error event", err_cnt, 1);
    check("reset count", rst_cnt, 1);
    check("irq count", irq_cnt, 1);
    repeat (100) @(posedge core_clk);
    rd_reg(8'h08); check("error flag", rd[15], 1);
    cnt(c1);
    repeat (100) @(posedge core_clk);
    cnt(c2); check("stop on error", c2, c1);
    wr(8'h08, 32'h0000_0000, 4'h2);
    rd_reg(8'h08); check("flags cleared", rd[15:14], 2'b00);
    refresh;
    repeat (8000) @(posedge core_clk);
    refresh;
    repeat (20) @(posedge core_clk);
    check("in window", err_cnt, 1);
    cnt(c1); check("window reload", c1 > 1000, 1);
    $display("window test done");
    wr(8'h10, 32'h0000_0001, 4'h1);
    check("stop output", cs_out, 1);
    lp <= 1'b1;
    repeat (10) @(posedge core_clk);
    cnt(c1);
    repeat (200) @(posedge core_clk);
    cnt(c2); check("frozen", c2, c1);
    wr(8'h10, 32'h0000_0000, 4'h1);
    check("stop output off", cs_out, 0);
    cnt(c1);
    repeat (200) @(posedge core_clk);
    cnt(c2); check("keeps counting", c2 < c1, 1);
    lp <= 1'b0;
    $display("count stop test done");
    for (i = 0; i < 3; i++) begin
      wr(8'h04, 32'h0000_3300 | tsel[i], 4'h3);
      refresh;
      cnt(c1);
      check("timeout load", c1 + 2 > tl[i] && c1 <= tl[i], 1);
    end
    $display("timeout test done");
    do_reset(1'b1);
    repeat (100) @(posedge core_clk);
    check("boot stop output", cs_out, 1);
    cnt(c1); check("auto start", c1 < 1023 && c1 > 900, 1);
    b = irq_cnt;
    wait_on(uf_cnt);
    check("boot irq", irq_cnt, b + 1);
    cnt(c1);
    repeat (100) @(posedge core_clk);
    cnt(c2); check("auto continues", c2 < c1, 1);
    $display("auto start test done");
    final_report;
  end
endmodule
`default_nettype wire
